// *** rtl/ccc_top.sv ***
/*
 Charger converter control: detect flag, current optimizer, light load,
 high impedance, reverse gating, discharge regulation.
 Assumes host bits on i_clock;
 comparators and straps are asynchronous.
*/
// How it works
// - Force-detect bit set by host, cleared by device when detection ends.
// - Optimizer idle after reset; runs only while its enable bit is one.
// - Dedicated port detection starts optimizer when enabled.
// - Force bit starts optimizer for any source, only when enabled.
// - Effective limit is optimizer result if enabled and started since enable, else programmed limit.
// - External pin clamps effective limit unless its enable bit is zero.
// - Battery above minimum: start at 500 mA and step upward.
// - Battery below minimum: start at programmed limit, step downward.
// - At optimum set state field and done flag, then hold the limit.
// - Plug-in, HIZ toggle, limit writes, force, input OV rerun; state 01.
// - Forward light-load disable keeps fixed frequency with DCM.
// - Forward audio guard keeps light-load frequency at or above 25 kHz.
// - Reverse mode uses its own light-load and audio guard disable bits.
// - HIZ turns regulator off, stops switching, ADC off unless its enable bit is one, battery switch on.
// - Overvoltage faults stop switching only; short or overcurrent set HIZ.
// - Reverse voltage setpoint is eleven bits, current setpoint seven.
// - Reverse needs battery ok, input under UVLO, thermistor in range.
// - Reverse start after 5 ms, or when a populated path drive is on.
// - Host clears active path then sets other; switching stops then resumes.
// - Over discharge limit: cut output, status, interrupt pulse, flag.
// - Discharge limit codes 3A, 4A, 5A with soft start; 11 disabled.
// - System regulation status high while held at minimum system voltage.
// - Path drive disable holds both path drives off.
// - Path population straps caught after reset into read-only status.
`timescale 1ns/1ps
module ccc_top #(
    parameter int unsigned REV_DELAY = ccc_pkg::REV_DELAY_CYC
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_force_detect_set,
    input wire logic i_detect_done,
    input wire logic i_optimizer_enable,
    input wire logic i_optimizer_force,
    input wire logic i_optimizer_flag_clear,
    input wire logic [ccc_pkg::LIM_W-1:0] i_input_current_limit,
    input wire logic i_input_current_limit_wr,
    input wire logic i_input_voltage_limit_wr,
    input wire logic [ccc_pkg::SRC_W-1:0] i_input_source_type,
    input wire logic i_external_limit_pin_enable,
    input wire logic [ccc_pkg::LIM_W-1:0] i_external_limit_pin,
    input wire logic i_forward_light_load_disable,
    input wire logic i_forward_audio_guard_disable,
    input wire logic i_reverse_light_load_disable,
    input wire logic i_reverse_audio_guard_disable,
    input wire logic i_hiz_wr,
    input wire logic i_hiz_wdata,
    input wire logic i_adc_enable,
    input wire logic i_reverse_mode_enable,
    input wire logic [ccc_pkg::VSET_W-1:0] i_reverse_voltage_setpoint,
    input wire logic [ccc_pkg::ISET_W-1:0] i_reverse_current_setpoint,
    input wire logic [ccc_pkg::TS_W-1:0] i_thermistor_reading,
    input wire logic [ccc_pkg::TS_W-1:0] i_thermistor_hot_limit,
    input wire logic [ccc_pkg::TS_W-1:0] i_thermistor_cold_limit,
    input wire logic i_path_drive_disable,
    input wire logic i_path1_drive_enable,
    input wire logic i_path2_drive_enable,
    input wire logic [1:0] i_discharge_limit,
    input wire logic i_discharge_regulation_mask,
    input wire logic i_discharge_flag_clear,
    input wire logic i_source_attach,
    input wire logic i_battery_above_min,
    input wire logic i_input_voltage_regulating,
    input wire logic i_input_overvoltage,
    input wire logic i_system_overvoltage,
    input wire logic i_battery_overvoltage,
    input wire logic i_reverse_overvoltage,
    input wire logic i_system_short,
    input wire logic i_input_overcurrent,
    input wire logic i_battery_above_reverse_min,
    input wire logic i_input_below_uvlo,
    input wire logic i_discharge_over_limit,
    input wire logic i_system_at_minimum,
    input wire logic i_path1_present,
    input wire logic i_path2_present,
    output logic o_force_limit_detect,
    output logic [1:0] o_optimizer_state,
    output logic o_optimizer_done_flag,
    output logic [ccc_pkg::LIM_W-1:0] o_effective_input_limit,
    output logic o_light_load_enable,
    output logic [4:0] o_min_switch_khz,
    output logic o_high_impedance_enable,
    output logic o_internal_regulator_on,
    output logic o_switching_enable,
    output logic o_adc_allowed,
    output logic o_battery_switch_force_on,
    output logic o_reverse_active,
    output logic [ccc_pkg::VSET_W-1:0] o_reverse_voltage_setpoint,
    output logic [ccc_pkg::ISET_W-1:0] o_reverse_current_setpoint,
    output logic o_path1_population_status,
    output logic o_path2_population_status,
    output logic o_path1_drive,
    output logic o_path2_drive,
    output logic o_discharge_regulation_status,
    output logic o_output_current_cut,
    output logic o_soft_start_enable,
    output logic [12:0] o_discharge_limit_ma,
    output logic o_interrupt_pulse,
    output logic o_discharge_regulation_flag,
    output logic o_system_regulation_status
);
    import ccc_pkg::*;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    logic [NSYNC-1:0] s1_ff, s2_ff;
    logic att, bat_min, vreg, ov_in, ov_sys, ov_bat, ov_rev;
    logic sys_short, in_oc, bat_rev, in_uvlo, dis_over, sys_min;
    logic p1_pres, p2_pres;
    logic [3:0] prv_ff;
    logic att_r, ovin_r, short_r, oc_r;

    // First stage feeds only the second
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_ff <= '0;
            s2_ff <= '0;
            prv_ff <= 4'h0;
        end else begin
            s1_ff <= {i_source_attach, i_battery_above_min,
                i_input_voltage_regulating, i_input_overvoltage,
                i_system_overvoltage, i_battery_overvoltage,
                i_reverse_overvoltage, i_system_short, i_input_overcurrent,
                i_battery_above_reverse_min, i_input_below_uvlo,
                i_discharge_over_limit, i_system_at_minimum,
                i_path1_present, i_path2_present};
            s2_ff <= s1_ff;
            prv_ff <= {att, ov_in, sys_short, in_oc};
        end
    end
    assign {att, bat_min, vreg, ov_in, ov_sys, ov_bat, ov_rev, sys_short,
        in_oc, bat_rev, in_uvlo, dis_over, sys_min, p1_pres, p2_pres} = s2_ff;
    assign {att_r, ovin_r, short_r, oc_r} =
        {att, ov_in, sys_short, in_oc} & ~prv_ff;

    // Caught once the synchroniser settles
    logic [1:0] pop_cnt_ff;
    logic pop1_ff, pop2_ff;
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pop_cnt_ff <= 2'h0;
            pop1_ff <= 1'b0;
            pop2_ff <= 1'b0;
        end else if (pop_cnt_ff != 2'h3) begin
            pop_cnt_ff <= pop_cnt_ff + 2'h1;
            if (pop_cnt_ff == 2'h2) begin
                pop1_ff <= p1_pres;
                pop2_ff <= p2_pres;
            end
        end
    end

    logic force_ff;
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            force_ff <= 1'b0;
        end else if (i_force_detect_set) begin
            force_ff <= 1'b1;
        end else if (i_detect_done) begin
            force_ff <= 1'b0;
        end
    end
    assign o_force_limit_detect = force_ff;

    logic hiz_ff, hiz_prv_ff;
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hiz_ff <= 1'b0;
            hiz_prv_ff <= 1'b0;
        end else begin
            hiz_prv_ff <= hiz_ff;
            // Fault entry wins over a host write
            if (short_r || oc_r) begin
                hiz_ff <= 1'b1;
            end else if (i_hiz_wr) begin
                hiz_ff <= i_hiz_wdata;
            end
        end
    end

    ccc_opt_e opt_st_ff;
    logic [LIM_W-1:0] lim_ff;
    logic [11:0] stp_ff;
    logic [1:0] ost_ff;
    logic dcp_ff, retrig, start, tick, fin;
    assign retrig = att_r || (hiz_ff != hiz_prv_ff)
        || i_input_current_limit_wr || i_input_voltage_limit_wr
        || i_optimizer_force || ovin_r;
    assign start = i_optimizer_enable && (retrig
        || (i_input_source_type == SRC_DCP && !dcp_ff));
    assign tick = stp_ff == 12'(STEP_CYC - 1);
    assign fin = i_optimizer_enable && !start && tick
        && ((opt_st_ff == OPT_UP && (vreg || lim_ff >= OPT_CAP))
        || (opt_st_ff == OPT_DOWN && (!vreg || lim_ff <= OPT_FLOOR)));

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dcp_ff <= 1'b0;
            stp_ff <= 12'h000;
        end else begin
            dcp_ff <= i_input_source_type == SRC_DCP;
            stp_ff <= (tick || start) ? 12'h000 : stp_ff + 12'h001;
        end
    end

    // Paced so the voltage loop settles between steps
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            opt_st_ff <= OPT_IDLE;
            lim_ff <= '0;
            ost_ff <= OST_OFF;
        end else if (!i_optimizer_enable) begin
            opt_st_ff <= OPT_IDLE;
            ost_ff <= OST_OFF;
        end else if (start) begin
            ost_ff <= OST_RUN;
            if (bat_min) begin
                opt_st_ff <= OPT_UP;
                lim_ff <= OPT_START_LIM;
            end else begin
                opt_st_ff <= OPT_DOWN;
                lim_ff <= i_input_current_limit;
            end
        end else if (fin) begin
            opt_st_ff <= OPT_HOLD;
            ost_ff <= OST_DONE;
            if (opt_st_ff == OPT_UP && vreg) begin
                lim_ff <= lim_ff - OPT_STEP;
            end
        end else if (tick) begin
            case (opt_st_ff)
                OPT_UP: lim_ff <= lim_ff + OPT_STEP;
                OPT_DOWN: lim_ff <= lim_ff - OPT_STEP;
                default: lim_ff <= lim_ff;
            endcase
        end
    end
    assign o_optimizer_state = ost_ff;

    logic flag_ff;
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            flag_ff <= 1'b0;
        end else if (fin) begin
            flag_ff <= 1'b1;
        end else if (i_optimizer_flag_clear) begin
            flag_ff <= 1'b0;
        end
    end
    assign o_optimizer_done_flag = flag_ff;

    ccc_rev_e rev_st_ff;
    logic [16:0] rev_cnt_ff;
    logic rev_ok, ts_ok, timer_mode, path_ok, rev_run;
    assign ts_ok = i_thermistor_reading >= i_thermistor_hot_limit
        && i_thermistor_reading <= i_thermistor_cold_limit;
    assign rev_ok = bat_rev && !ov_bat && in_uvlo && ts_ok;
    assign timer_mode = i_path_drive_disable || !(pop1_ff || pop2_ff);
    assign path_ok = (pop1_ff && i_path1_drive_enable)
        || (pop2_ff && i_path2_drive_enable);
    assign rev_run = rev_st_ff == REV_RUN;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rev_st_ff <= REV_OFF;
            rev_cnt_ff <= 17'h0_0000;
        end else if (!i_reverse_mode_enable || !rev_ok) begin
            rev_st_ff <= REV_OFF;
            rev_cnt_ff <= 17'h0_0000;
        end else begin
            case (rev_st_ff)
                REV_OFF: rev_st_ff <= REV_WAIT;
                REV_WAIT: begin
                    if (timer_mode) begin
                        if (rev_cnt_ff >= 17'(REV_DELAY - 1)) begin
                            rev_st_ff <= REV_RUN;
                        end
                        rev_cnt_ff <= rev_cnt_ff + 17'h0_0001;
                    end else if (path_ok) begin
                        rev_st_ff <= REV_RUN;
                    end
                end
                REV_RUN: begin
                    rev_cnt_ff <= 17'h0_0000;
                    // Path dropped: wait for another
                    if (!timer_mode && !path_ok) begin
                        rev_st_ff <= REV_WAIT;
                    end
                end
                default: rev_st_ff <= REV_OFF;
            endcase
        end
    end

    logic dis_act, ll_dis, ag_dis;
    assign dis_act = rev_run && dis_over && i_discharge_limit != DIS_OFF;
    assign ll_dis = rev_run ? i_reverse_light_load_disable
        : i_forward_light_load_disable;
    assign ag_dis = rev_run ? i_reverse_audio_guard_disable
        : i_forward_audio_guard_disable;

    logic [LIM_W-1:0] base_lim;
    assign base_lim = (i_optimizer_enable && opt_st_ff != OPT_IDLE)
        ? lim_ff : i_input_current_limit;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_effective_input_limit <= '0;
            o_light_load_enable <= 1'b0;
            o_min_switch_khz <= 5'h00;
            o_high_impedance_enable <= 1'b0;
            o_internal_regulator_on <= 1'b0;
            o_switching_enable <= 1'b0;
            o_adc_allowed <= 1'b0;
            o_battery_switch_force_on <= 1'b0;
            o_reverse_active <= 1'b0;
            o_reverse_voltage_setpoint <= '0;
            o_reverse_current_setpoint <= '0;
            o_path1_population_status <= 1'b0;
            o_path2_population_status <= 1'b0;
            o_path1_drive <= 1'b0;
            o_path2_drive <= 1'b0;
            o_system_regulation_status <= 1'b0;
        end else begin
            o_effective_input_limit <= (i_external_limit_pin_enable
                && i_external_limit_pin < base_lim)
                ? i_external_limit_pin : base_lim;
            o_light_load_enable <= !ll_dis;
            o_min_switch_khz <= ag_dis ? 5'h00 : AUDIO_FLOOR_KHZ;
            o_high_impedance_enable <= hiz_ff;
            o_internal_regulator_on <= !hiz_ff;
            o_switching_enable <= !hiz_ff
                && !(ov_in || ov_sys || ov_bat || ov_rev)
                && (!i_reverse_mode_enable || rev_run);
            o_adc_allowed <= !hiz_ff || i_adc_enable;
            o_battery_switch_force_on <= hiz_ff;
            o_reverse_active <= rev_run;
            o_reverse_voltage_setpoint <= i_reverse_voltage_setpoint;
            o_reverse_current_setpoint <= i_reverse_current_setpoint;
            o_path1_population_status <= pop1_ff;
            o_path2_population_status <= pop2_ff;
            o_path1_drive <= !i_path_drive_disable
                && pop1_ff && i_path1_drive_enable;
            o_path2_drive <= !i_path_drive_disable
                && pop2_ff && i_path2_drive_enable;
            o_system_regulation_status <= sys_min;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_discharge_regulation_status <= 1'b0;
            o_output_current_cut <= 1'b0;
            o_interrupt_pulse <= 1'b0;
            o_discharge_regulation_flag <= 1'b0;
            o_soft_start_enable <= 1'b0;
            o_discharge_limit_ma <= 13'h0000;
        end else begin
            o_discharge_regulation_status <= dis_act;
            o_output_current_cut <= dis_act;
            o_interrupt_pulse <= dis_act && !o_discharge_regulation_status;
            if (dis_act && !o_discharge_regulation_status
                && !i_discharge_regulation_mask) begin
                o_discharge_regulation_flag <= 1'b1;
            end else if (i_discharge_flag_clear) begin
                o_discharge_regulation_flag <= 1'b0;
            end
            o_soft_start_enable <= i_discharge_limit != DIS_OFF;
            case (i_discharge_limit)
                DIS_3A: o_discharge_limit_ma <= DIS_3A_MA;
                DIS_4A: o_discharge_limit_ma <= DIS_4A_MA;
                DIS_5A: o_discharge_limit_ma <= DIS_5A_MA;
                default: o_discharge_limit_ma <= 13'h0000;
            endcase
        end
    end

    chk_force_self_clear: assert property (
        force_ff && i_detect_done && !i_force_detect_set |=> !force_ff)
        else $error("force bit stuck");
    chk_opt_disabled: assert property (
        !i_optimizer_enable |=> ost_ff == OST_OFF && opt_st_ff == OPT_IDLE)
        else $error("optimizer not idle");
    chk_opt_start_up: assert property (
        start && bat_min |=> lim_ff == OPT_START_LIM && ost_ff == OST_RUN)
        else $error("bad start limit");
    chk_ext_clamp: assert property (
        i_external_limit_pin_enable |=>
        o_effective_input_limit <= $past(i_external_limit_pin))
        else $error("limit above pin");
    chk_hiz_off: assert property (
        hiz_ff |=> !o_internal_regulator_on && !o_switching_enable
        && o_battery_switch_force_on)
        else $error("bad hiz outputs");
    chk_fault_hiz: assert property (
        $rose(sys_short) || $rose(in_oc) |=>
        hiz_ff ##1 o_high_impedance_enable)
        else $error("no fault hiz");
    chk_rev_delay: assert property (
        rev_st_ff == REV_WAIT && timer_mode
        && rev_cnt_ff < 17'(REV_DELAY - 1) |=> rev_st_ff != REV_RUN)
        else $error("early reverse");
    chk_path_gate: assert property (
        i_path_drive_disable |=> !o_path1_drive && !o_path2_drive)
        else $error("path drive on");
    chk_dis_flag: assert property (
        dis_act && !o_discharge_regulation_status
        && !i_discharge_regulation_mask |=> o_interrupt_pulse
        && o_discharge_regulation_flag ##1 !o_interrupt_pulse)
        else $error("no discharge event");
endmodule

// *** shared/ccc_pkg.sv ***
/*
 Constants and types of the charger converter control.
 Assumes one 20 MHz clock; limits in 10 mA steps.
*/
package ccc_pkg;
    localparam int CLK_KHZ = 20000;
    localparam int REV_DELAY_US = 5000;
    localparam int REV_DELAY_CYC = REV_DELAY_US * CLK_KHZ / 1000;
    localparam int STEP_US = 100;
    localparam int STEP_CYC = (STEP_US * CLK_KHZ + 999) / 1000;
    localparam int LIM_W = 9;
    localparam int VSET_W = 11;
    localparam int ISET_W = 7;
    localparam int TS_W = 8;
    localparam int SRC_W = 3;
    localparam logic [LIM_W-1:0] OPT_START_LIM = 9'h032;
    localparam logic [LIM_W-1:0] OPT_STEP = 9'h005;
    localparam logic [LIM_W-1:0] OPT_CAP = 9'h14a;
    localparam logic [LIM_W-1:0] OPT_FLOOR = 9'h00a;
    localparam logic [SRC_W-1:0] SRC_DCP = 3'h3;
    localparam logic [1:0] OST_OFF = 2'h0;
    localparam logic [1:0] OST_RUN = 2'h1;
    localparam logic [1:0] OST_DONE = 2'h2;
    localparam logic [4:0] AUDIO_FLOOR_KHZ = 5'h19;
    localparam logic [1:0] DIS_3A = 2'h0;
    localparam logic [1:0] DIS_4A = 2'h1;
    localparam logic [1:0] DIS_5A = 2'h2;
    localparam logic [1:0] DIS_OFF = 2'h3;
    localparam logic [12:0] DIS_3A_MA = 13'h0bb8;
    localparam logic [12:0] DIS_4A_MA = 13'h0fa0;
    localparam logic [12:0] DIS_5A_MA = 13'h1388;
    localparam int NSYNC = 15;
    typedef enum logic [1:0] {OPT_IDLE, OPT_UP, OPT_DOWN, OPT_HOLD} ccc_opt_e;
    typedef enum logic [1:0] {REV_OFF, REV_WAIT, REV_RUN} ccc_rev_e;
endpackage

// *** verif/ccc_source_model.sv ***
/*
 Source model: sags at a 600 mA limit; both path pairs fitted; no input.
 Assumes the converter control's clock.
*/
`timescale 1ns/1ps
module ccc_source_model (
    input wire logic i_clock,
    input wire logic [ccc_pkg::LIM_W-1:0] i_limit,
    output logic o_regulating,
    output logic o_path1,
    output logic o_path2,
    output logic o_uvlo
);
    // Answers a cycle late, like an adapter
    always_ff @(posedge i_clock) begin
        o_regulating <= (i_limit >= 9'h03c);
    end
    assign o_path1 = 1'b1;
    assign o_path2 = 1'b1;
    assign o_uvlo = 1'b1;
endmodule

// *** verif/test_ccc_top.sv ***
/*
 Bench for the charger converter control.
 Assumes the source model; REV_DELAY is 50.
*/
`timescale 1ns/1ps
module test_ccc_top;
    import ccc_pkg::*;
    logic i_clock=0, i_rst_b=0, i_force_detect_set=0, i_detect_done=0;
    logic i_optimizer_enable=0, i_optimizer_force=0, i_hiz_wr=0;
    logic i_optimizer_flag_clear=0, i_input_current_limit_wr=0;
    logic i_input_voltage_limit_wr=0, i_external_limit_pin_enable=0;
    logic i_forward_light_load_disable=0, i_forward_audio_guard_disable=0;
    logic i_reverse_light_load_disable=0, i_reverse_audio_guard_disable=0;
    logic i_hiz_wdata=0, i_adc_enable=0, i_reverse_mode_enable=0;
    logic i_path_drive_disable=0, i_path1_drive_enable=0;
    logic i_path2_drive_enable=0, i_discharge_regulation_mask=0;
    logic i_discharge_flag_clear=0, i_source_attach=0;
    logic i_battery_above_min=1, i_input_overvoltage=0;
    logic i_system_overvoltage=0, i_battery_overvoltage=0;
    logic i_reverse_overvoltage=0, i_system_short=0, i_input_overcurrent=0;
    logic i_battery_above_reverse_min=1, i_discharge_over_limit=0;
    logic i_system_at_minimum=0;
    wire i_input_voltage_regulating, i_path1_present, i_path2_present;
    wire i_input_below_uvlo;
    logic [LIM_W-1:0] i_input_current_limit=0, i_external_limit_pin=0;
    logic [SRC_W-1:0] i_input_source_type=0;
    logic [VSET_W-1:0] i_reverse_voltage_setpoint=0;
    logic [ISET_W-1:0] i_reverse_current_setpoint=0;
    logic [TS_W-1:0] i_thermistor_reading=8'h80, i_thermistor_hot_limit=8'h20;
    logic [TS_W-1:0] i_thermistor_cold_limit=8'hc0;
    logic [1:0] i_discharge_limit=2'h3, o_optimizer_state;
    logic o_force_limit_detect, o_optimizer_done_flag, o_light_load_enable;
    logic o_high_impedance_enable, o_internal_regulator_on, o_adc_allowed;
    logic o_switching_enable, o_battery_switch_force_on, o_reverse_active;
    logic o_path1_population_status, o_path2_population_status;
    logic o_path1_drive, o_path2_drive, o_discharge_regulation_status;
    logic o_output_current_cut, o_soft_start_enable, o_interrupt_pulse;
    logic o_discharge_regulation_flag, o_system_regulation_status;
    logic [LIM_W-1:0] o_effective_input_limit;
    logic [4:0] o_min_switch_khz;
    logic [VSET_W-1:0] o_reverse_voltage_setpoint;
    logic [ISET_W-1:0] o_reverse_current_setpoint;
    logic [12:0] o_discharge_limit_ma;
    logic [15:0] obs [24];
    logic [20:0] q [$];
    logic [20:0] note;
    int n_errors = 0;
    int checks_done = 0;
    int i, c;

    ccc_top #(.REV_DELAY(50)) uut (.*);
    ccc_source_model model (.i_clock(i_clock),
        .i_limit(o_effective_input_limit),
        .o_regulating(i_input_voltage_regulating),
        .o_path1(i_path1_present), .o_path2(i_path2_present),
        .o_uvlo(i_input_below_uvlo));

    assign obs = '{16'(o_force_limit_detect), 16'(o_optimizer_state),
        16'(o_optimizer_done_flag), 16'(o_effective_input_limit),
        16'(o_light_load_enable), 16'(o_min_switch_khz),
        16'(o_high_impedance_enable), 16'(o_internal_regulator_on),
        16'(o_switching_enable), 16'(o_adc_allowed),
        16'(o_battery_switch_force_on), 16'(o_reverse_active),
        16'(o_reverse_voltage_setpoint), 16'(o_reverse_current_setpoint),
        16'({o_path1_population_status, o_path2_population_status}),
        16'({o_path1_drive, o_path2_drive}),
        16'(o_discharge_regulation_status), 16'(o_output_current_cut),
        16'(o_soft_start_enable), 16'(o_discharge_limit_ma),
        16'(o_interrupt_pulse), 16'(o_discharge_regulation_flag),
        16'(o_system_regulation_status),
        16'(o_effective_input_limit < 9'h03c)};

    always #25 i_clock = ~i_clock;

    task check(input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task results;
        if (n_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task want(input int s, input logic [15:0] e);
        q.push_back({5'(s), e});
        @(negedge i_clock);
        @(posedge i_clock);
    endtask

    task cyc(input int n);
        repeat (n) @(posedge i_clock);
    endtask

    task wait_done;
        for (i = 0; i < 25000 && o_optimizer_state !== OST_DONE; i++) cyc(1);
        cyc(2);
    endtask

    always @(negedge i_clock) begin
        if (q.size() > 0) begin
            note = q.pop_front();
            check(obs[note[20:16]], note[15:0]);
        end
    end

    initial begin
        #(60000 * 50);
        n_errors++;
        results;
    end

    initial begin
        void'($urandom(32'hdbf3f19e));
        cyc(12);
        i_rst_b <= 1;
        cyc(6);
        want(1, 16'h0000);
        want(14, 16'h0003);
        @(posedge i_clock) i_force_detect_set <= 1;
        @(posedge i_clock) i_force_detect_set <= 0;
        want(0, 16'h0001);
        @(posedge i_clock) i_detect_done <= 1;
        @(posedge i_clock) i_detect_done <= 0;
        want(0, 16'h0000);
        @(posedge i_clock) i_optimizer_force <= 1;
        @(posedge i_clock) i_optimizer_force <= 0;
        cyc(2);
        want(1, 16'h0000);
        i_optimizer_enable <= 1;
        i_input_source_type <= SRC_DCP;
        cyc(4);
        want(1, 16'h0001);
        want(3, 16'h0032);
        wait_done;
        want(1, 16'h0002);
        want(2, 16'h0001);
        want(3, 16'h0037);
        cyc(2500);
        want(3, 16'h0037);
        i_external_limit_pin <= 9'h028;
        i_external_limit_pin_enable <= 1;
        cyc(3);
        want(3, 16'h0028);
        i_external_limit_pin_enable <= 0;
        i_optimizer_enable <= 0;
        i_input_current_limit <= 9'h064;
        i_battery_above_min <= 0;
        cyc(3);
        want(3, 16'h0064);
        i_optimizer_enable <= 1;
        @(posedge i_clock) i_input_current_limit_wr <= 1;
        @(posedge i_clock) i_input_current_limit_wr <= 0;
        cyc(2);
        want(1, 16'h0001);
        want(3, 16'h0064);
        wait_done;
        want(23, 16'h0001);
        i_forward_light_load_disable <= 1;
        cyc(2);
        want(4, 16'h0000);
        i_forward_light_load_disable <= 0;
        cyc(2);
        want(5, 16'h0019);
        i_forward_audio_guard_disable <= 1;
        cyc(2);
        want(5, 16'h0000);
        i_forward_audio_guard_disable <= 0;
        for (c = 1; c >= 0; c--) begin
            i_hiz_wdata <= c[0];
            @(posedge i_clock) i_hiz_wr <= 1;
            @(posedge i_clock) i_hiz_wr <= 0;
            cyc(2);
            want(7, 16'(!c[0]));
            want(9, 16'(!c[0]));
            want(10, 16'(c[0]));
        end
        want(1, 16'h0001);
        i_input_overvoltage <= 1;
        cyc(4);
        want(8, 16'h0000);
        want(7, 16'h0001);
        i_input_overvoltage <= 0;
        i_system_short <= 1;
        cyc(4);
        want(6, 16'h0001);
        i_system_short <= 0;
        @(posedge i_clock) i_hiz_wr <= 1;
        @(posedge i_clock) i_hiz_wr <= 0;
        i_reverse_voltage_setpoint <= 11'($urandom);
        i_reverse_current_setpoint <= 7'($urandom);
        i_thermistor_reading <= 8'h10;
        i_path_drive_disable <= 1;
        i_path1_drive_enable <= 1;
        i_reverse_mode_enable <= 1;
        cyc(70);
        want(11, 16'h0000);
        want(12, 16'(i_reverse_voltage_setpoint));
        want(13, 16'(i_reverse_current_setpoint));
        i_thermistor_reading <= 8'h80;
        cyc(40);
        want(11, 16'h0000);
        cyc(30);
        want(11, 16'h0001);
        want(15, 16'h0000);
        i_reverse_light_load_disable <= 1;
        i_reverse_audio_guard_disable <= 1;
        cyc(2);
        want(4, 16'h0000);
        want(5, 16'h0000);
        for (c = 0; c < 4; c++) begin
            i_discharge_limit <= 2'(c);
            cyc(2);
            want(19, 16'(c == 3 ? 0 : 3000 + 1000 * c));
            want(18, 16'(c != 3));
        end
        i_discharge_limit <= DIS_3A;
        i_discharge_over_limit <= 1;
        cyc(5);
        want(16, 16'h0001);
        want(17, 16'h0001);
        want(21, 16'h0001);
        want(20, 16'h0000);
        i_discharge_over_limit <= 0;
        i_discharge_regulation_mask <= 1;
        @(posedge i_clock) i_discharge_flag_clear <= 1;
        @(posedge i_clock) i_discharge_flag_clear <= 0;
        i_discharge_over_limit <= 1;
        cyc(5);
        want(16, 16'h0001);
        want(21, 16'h0000);
        i_discharge_limit <= DIS_OFF;
        cyc(4);
        want(16, 16'h0000);
        i_reverse_mode_enable <= 0;
        i_path_drive_disable <= 0;
        i_path1_drive_enable <= 0;
        cyc(3);
        i_reverse_mode_enable <= 1;
        cyc(70);
        want(11, 16'h0000);
        i_path1_drive_enable <= 1;
        cyc(4);
        want(11, 16'h0001);
        want(15, 16'h0002);
        i_path1_drive_enable <= 0;
        cyc(4);
        want(8, 16'h0000);
        i_path2_drive_enable <= 1;
        cyc(4);
        want(8, 16'h0001);
        want(15, 16'h0001);
        i_system_at_minimum <= 1;
        cyc(4);
        want(22, 16'h0001);
        results;
    end
endmodule
